// ===== pkg/flash_regs_pkg.sv
/*
  shared constants and types of the flash status and configuration register bank:
  instruction codes, field layouts of the three registers, reset values and timing.
  assumes a 40 MHz system clock and a serial link sampled by that clock.
*/
`default_nettype none
package flash_regs_pkg;

  // instruction codes
  localparam logic [7:0] OP_READ_FIRST = 8'h05;
  localparam logic [7:0] OP_READ_SECOND = 8'h35;
  localparam logic [7:0] OP_READ_THIRD = 8'h15;
  localparam logic [7:0] OP_WRITE_FIRST = 8'h01;
  localparam logic [7:0] OP_WRITE_SECOND = 8'h31;
  localparam logic [7:0] OP_WRITE_THIRD = 8'h11;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
  localparam logic [7:0] OP_ENTER_WIDE_ADDR = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE_ADDR = 8'he9;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_SECURE_ERASE = 8'h44;
  localparam logic [7:0] OP_SECURE_PROG = 8'h42;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // register-protect scheme encodings {hi, lo}
  localparam logic [1:0] PROT_SOFTWARE = 2'h0;
  localparam logic [1:0] PROT_HARDWARE = 2'h1;
  localparam logic [1:0] PROT_LOCKDOWN = 2'h2;

  // first register, bit 7 down to bit 0
  typedef struct packed {
    logic reg_protect_lo;
    logic top_bottom_select;
    logic block_protect_b3;
    logic block_protect_b2;
    logic block_protect_b1;
    logic block_protect_b0;
    logic write_enable_latch;
    logic busy;
  } status_first_t;

  // second register, bit 15 down to bit 8
  typedef struct packed {
    logic suspend_flag;
    logic protect_complement;
    logic secure_lock_3;
    logic secure_lock_2;
    logic secure_lock_1;
    logic spare_10;
    logic quad_enable;
    logic reg_protect_hi;
  } status_second_t;

  // third register, bit 23 down to bit 16
  typedef struct packed {
    logic hold_reset_select;
    logic drive_strength_hi;
    logic drive_strength_lo;
    logic spare_20;
    logic spare_19;
    logic protect_scheme_select;
    logic powerup_addr_mode;
    logic current_addr_mode;
  } status_third_t;

  typedef struct packed {
    status_third_t third;
    status_second_t second;
    status_first_t first;
  } status_all_t;

  // factory values
  localparam status_first_t FIRST_RESET = 8'h00;
  localparam status_second_t SECOND_RESET = 8'h00;
  localparam status_third_t THIRD_RESET = 8'h60;

  // events from the serial link front end
  typedef struct packed {
    logic frame_start;
    logic frame_end;
    logic aligned;
    logic byte_valid;
    logic [7:0] byte_data;
    logic hold_level;
  } link_ev_t;

  // idle pin levels {hold, data in, select, serial clock}
  localparam logic [3:0] LINK_IDLE = 4'ha;

  // internal operation time
  localparam int CLK_HZ = 40_000_000;
  localparam int BUSY_TIME_US = 50;
  localparam int BUSY_CYCLES = BUSY_TIME_US * (CLK_HZ / 1_000_000);
  localparam int BUSY_CNT_W = 12;

  // operation engine states, gray along idle, run, suspended
  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_RUN = 2'h1,
    OP_SUSP = 2'h3
  } op_state_t;

endpackage : flash_regs_pkg
`default_nettype wire

// ===== logic/flash_spi_link.sv
/*
  serial link front end: synchronises the pins, finds serial clock edges,
  assembles bytes msb first and shifts read data out on falling edges.
  assumes the serial clock runs at most at one eighth of clk.
*/
`default_nettype none
module flash_spi_link
  import flash_regs_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic di,
  input wire logic hold_pin_n,
  output logic do_out,
  output logic do_oe,
  // block side
  input wire logic hold_enable,
  input wire logic tx_enable,
  input wire logic [7:0] tx_byte,
  output link_ev_t ev
);

  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_in_reg;
  logic [6:0] shift_out_reg;
  logic held;
  logic rise;
  logic fall;

  // two-stage synchroniser for all pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= LINK_IDLE;
      sync_reg <= LINK_IDLE;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= {hold_pin_n, di, cs_n, sclk};
      sync_reg <= meta_reg;
      sclk_prev_reg <= sync_reg[0];
      cs_prev_reg <= sync_reg[1];
    end
  end

  // hold pauses the link: clock edges are ignored and output floats
  assign held = hold_enable & ~sync_reg[3];
  assign rise = sync_reg[0] & ~sclk_prev_reg & ~sync_reg[1] & ~held;
  assign fall = ~sync_reg[0] & sclk_prev_reg & ~sync_reg[1] & ~held;

  // receive shifter and bit counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 7'h00;
    end
    else if (sync_reg[1])
      bit_cnt_reg <= 3'h0;
    else if (rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_in_reg <= {shift_in_reg[5:0], sync_reg[2]};
    end
  end

  // event pulses to the register bank
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ev <= '{hold_level: 1'b1, default: '0}; // hold pin idles high
    else
    begin
      ev.frame_start <= cs_prev_reg & ~sync_reg[1];
      ev.frame_end <= ~cs_prev_reg & sync_reg[1];
      ev.aligned <= (bit_cnt_reg == 3'h0);
      ev.byte_valid <= rise & (bit_cnt_reg == 3'h7);
      ev.byte_data <= {shift_in_reg, sync_reg[2]};
      ev.hold_level <= sync_reg[3];
    end
  end

  // transmit shifter, a new byte is taken at each byte boundary
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      do_out <= 1'b0;
      do_oe <= 1'b0;
      shift_out_reg <= 7'h00;
    end
    else
    begin
      do_oe <= ~sync_reg[1] & tx_enable & ~held;
      if (fall)
      begin
        if (bit_cnt_reg == 3'h0)
        begin
          do_out <= tx_byte[7];
          shift_out_reg <= tx_byte[6:0];
        end
        else
        begin
          do_out <= shift_out_reg[6];
          shift_out_reg <= {shift_out_reg[5:0], 1'b0};
        end
      end
    end
  end

endmodule : flash_spi_link
`default_nettype wire

// ===== logic/flash_status_config_regs.sv
/*
  status and configuration register bank of a serial flash: three 8-bit registers
  read and written by serial instructions, with write protection, suspend,
  address mode and pin-function settings.
  assumes a 40 MHz clk, pins arriving from outside, and rst_n standing for power-up.
*/
`default_nettype none
module flash_status_config_regs
  import flash_regs_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io0_di,
  input wire logic wp_io2_n,
  input wire logic hold_io3_n,
  output logic io1_out,
  output logic io1_oe,
  // state toward the rest of the device
  output status_all_t status_out,
  output logic quad_instruction_mode,
  output logic block_locks_set
);

  link_ev_t ev;
  logic [1:0] wp_meta_reg;
  op_state_t op_state_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic write_enable_latch_reg;
  logic current_addr_mode_reg;
  logic quad_instruction_mode_reg;
  logic reset_armed_reg;
  logic [7:0] opcode_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] data1_reg;
  logic [7:0] data2_reg;
  logic frame_ok_reg;
  logic tx_enable_reg;
  logic [7:0] tx_byte_reg;
  status_first_t first_cfg_reg;
  status_second_t second_cfg_reg;
  status_third_t third_cfg_reg;
  status_first_t first_view;
  status_second_t second_view;
  status_third_t third_view;
  logic busy;
  logic exec;
  logic dev_reset;
  logic wp_high;
  logic write_allowed;
  logic is_array_op;
  logic start_op;
  logic cfg_write;
  logic [1:0] protect_mode;

  flash_spi_link u_link (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .di(io0_di),
    .hold_pin_n(hold_io3_n),
    .do_out(io1_out),
    .do_oe(io1_oe),
    .hold_enable(~third_cfg_reg.hold_reset_select & ~second_cfg_reg.quad_enable),
    .tx_enable(tx_enable_reg),
    .tx_byte(tx_byte_reg),
    .ev(ev)
  );

  // protect pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wp_meta_reg <= 2'h3;
    else
      wp_meta_reg <= {wp_meta_reg[0], wp_io2_n};
  end

  // live view of the registers with the read-only bits filled in
  always_comb
  begin
    first_view = first_cfg_reg;
    first_view.busy = busy;
    first_view.write_enable_latch = write_enable_latch_reg;
    second_view = second_cfg_reg;
    second_view.suspend_flag = (op_state_reg == OP_SUSP);
    second_view.spare_10 = 1'b0;
    third_view = third_cfg_reg;
    third_view.current_addr_mode = current_addr_mode_reg;
    third_view.spare_19 = 1'b0;
    third_view.spare_20 = 1'b0;
  end

  assign busy = (op_state_reg == OP_RUN);
  assign protect_mode = {second_cfg_reg.reg_protect_hi, first_cfg_reg.reg_protect_lo};
  // with quad enable set the protect pin is a data line and never blocks
  assign wp_high = wp_meta_reg[1] | second_cfg_reg.quad_enable;
  // register writes need the latch and a permitting scheme
  assign write_allowed = write_enable_latch_reg &
    ((protect_mode == PROT_SOFTWARE) |
     ((protect_mode == PROT_HARDWARE) & wp_high));
  // a frame is executed at its end when it finished on a byte boundary
  assign exec = ev.frame_end & ev.aligned & frame_ok_reg & (byte_cnt_reg != 2'h0);
  assign is_array_op = (opcode_reg == OP_PAGE_PROG) | (opcode_reg == OP_QUAD_PAGE_PROG) |
    (opcode_reg == OP_SECTOR_ERASE) | (opcode_reg == OP_BLOCK32_ERASE) |
    (opcode_reg == OP_BLOCK64_ERASE) | (opcode_reg == OP_CHIP_ERASE) |
    (opcode_reg == OP_SECURE_ERASE) | (opcode_reg == OP_SECURE_PROG);
  // no register write while an operation runs or is suspended, so busy follows it unless dev_reset comes in the same cycle
  assign cfg_write = exec & write_allowed & (byte_cnt_reg >= 2'h2) & (op_state_reg == OP_IDLE) &
    ((opcode_reg == OP_WRITE_FIRST) | (opcode_reg == OP_WRITE_SECOND) | (opcode_reg == OP_WRITE_THIRD));
  assign start_op = cfg_write |
    (exec & is_array_op & write_enable_latch_reg & (op_state_reg == OP_IDLE));
  // software reset pair, or the shared pin as reset input
  assign dev_reset = (exec & reset_armed_reg & (opcode_reg == OP_RESET)) |
    (third_cfg_reg.hold_reset_select & ~second_cfg_reg.quad_enable & ~ev.hold_level);

  // frame decode: opcode, byte count, data bytes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      opcode_reg <= 8'h00;
      byte_cnt_reg <= 2'h0;
      data1_reg <= 8'h00;
      data2_reg <= 8'h00;
      frame_ok_reg <= 1'b0;
    end
    else if (ev.frame_start)
      byte_cnt_reg <= 2'h0;
    else if (ev.byte_valid)
    begin
      if (byte_cnt_reg != 2'h3)
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      if (byte_cnt_reg == 2'h0)
      begin
        opcode_reg <= ev.byte_data;
        frame_ok_reg <= ~busy | (ev.byte_data == OP_READ_FIRST) | (ev.byte_data == OP_READ_SECOND) |
          (ev.byte_data == OP_READ_THIRD) | (ev.byte_data == OP_SUSPEND);
      end
      else if (byte_cnt_reg == 2'h1)
        data1_reg <= ev.byte_data;
      else if (byte_cnt_reg == 2'h2)
        data2_reg <= ev.byte_data;
    end
  end

  // read data: the addressed register repeats for as long as the frame runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_enable_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
    end
    else if (ev.frame_start)
      tx_enable_reg <= 1'b0;
    else if (ev.byte_valid)
    begin
      case ((byte_cnt_reg == 2'h0) ? ev.byte_data : opcode_reg)
        OP_READ_FIRST:
        begin
          tx_enable_reg <= 1'b1;
          tx_byte_reg <= first_view;
        end
        OP_READ_SECOND:
        begin
          tx_enable_reg <= 1'b1;
          tx_byte_reg <= second_view;
        end
        OP_READ_THIRD:
        begin
          tx_enable_reg <= 1'b1;
          tx_byte_reg <= third_view;
        end
        default:
          tx_enable_reg <= 1'b0;
      endcase
    end
  end

  // operation engine: run timer, suspend and resume
  always_ff @(posedge clk)
  begin
    if (!rst_n || dev_reset)
    begin
      op_state_reg <= OP_IDLE;
      busy_cnt_reg <= '0;
    end
    else
    begin
      case (op_state_reg)
        OP_IDLE:
          if (start_op)
          begin
            op_state_reg <= OP_RUN;
            busy_cnt_reg <= BUSY_CNT_W'(BUSY_CYCLES);
          end
        OP_RUN:
          if (exec && opcode_reg == OP_SUSPEND)
            op_state_reg <= OP_SUSP;
          else if (busy_cnt_reg <= BUSY_CNT_W'(1))
            op_state_reg <= OP_IDLE;
          else
            busy_cnt_reg <= busy_cnt_reg - BUSY_CNT_W'(1);
        OP_SUSP:
          if (exec && opcode_reg == OP_RESUME)
            op_state_reg <= OP_RUN;
        default:
          op_state_reg <= OP_IDLE;
      endcase
    end
  end

  // write enable latch
  always_ff @(posedge clk)
  begin
    if (!rst_n || dev_reset)
      write_enable_latch_reg <= 1'b0;
    else if (start_op || (exec && opcode_reg == OP_WRITE_DISABLE))
      write_enable_latch_reg <= 1'b0;
    else if (exec && opcode_reg == OP_WRITE_ENABLE)
      write_enable_latch_reg <= 1'b1;
  end

  // retained configuration bits, loaded with factory values at power-up
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_cfg_reg <= FIRST_RESET;
      second_cfg_reg <= SECOND_RESET;
      third_cfg_reg <= THIRD_RESET;
    end
    else if (cfg_write)
    begin
      if (opcode_reg == OP_WRITE_FIRST)
      begin
        // busy and latch positions are dropped from the written byte
        first_cfg_reg.block_protect_b0 <= data1_reg[2];
        first_cfg_reg.block_protect_b1 <= data1_reg[3];
        first_cfg_reg.block_protect_b2 <= data1_reg[4];
        first_cfg_reg.block_protect_b3 <= data1_reg[5];
        first_cfg_reg.top_bottom_select <= data1_reg[6];
        first_cfg_reg.reg_protect_lo <= data1_reg[7];
      end
      if ((opcode_reg == OP_WRITE_SECOND) || (opcode_reg == OP_WRITE_FIRST && byte_cnt_reg == 2'h3))
      begin
        second_cfg_reg.reg_protect_hi <= (opcode_reg == OP_WRITE_SECOND) ? data1_reg[0] : data2_reg[0];
        second_cfg_reg.quad_enable <= ((opcode_reg == OP_WRITE_SECOND) ? data1_reg[1] : data2_reg[1]) |
          quad_instruction_mode_reg;
        second_cfg_reg.secure_lock_1 <= second_cfg_reg.secure_lock_1 |
          ((opcode_reg == OP_WRITE_SECOND) ? data1_reg[3] : data2_reg[3]);
        second_cfg_reg.secure_lock_2 <= second_cfg_reg.secure_lock_2 |
          ((opcode_reg == OP_WRITE_SECOND) ? data1_reg[4] : data2_reg[4]);
        second_cfg_reg.secure_lock_3 <= second_cfg_reg.secure_lock_3 |
          ((opcode_reg == OP_WRITE_SECOND) ? data1_reg[5] : data2_reg[5]);
        second_cfg_reg.protect_complement <= (opcode_reg == OP_WRITE_SECOND) ? data1_reg[6] : data2_reg[6];
      end
      if (opcode_reg == OP_WRITE_THIRD)
      begin
        third_cfg_reg.powerup_addr_mode <= data1_reg[1];
        third_cfg_reg.protect_scheme_select <= data1_reg[2];
        third_cfg_reg.drive_strength_lo <= data1_reg[5];
        third_cfg_reg.drive_strength_hi <= data1_reg[6];
        third_cfg_reg.hold_reset_select <= data1_reg[7];
      end
    end
  end

  // address mode and quad instruction mode
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      current_addr_mode_reg <= 1'b0;
      quad_instruction_mode_reg <= 1'b0;
    end
    else if (dev_reset)
    begin
      current_addr_mode_reg <= third_cfg_reg.powerup_addr_mode;
      quad_instruction_mode_reg <= 1'b0;
    end
    else if (exec)
    begin
      if (opcode_reg == OP_ENTER_WIDE_ADDR)
        current_addr_mode_reg <= 1'b1;
      else if (opcode_reg == OP_EXIT_WIDE_ADDR)
        current_addr_mode_reg <= 1'b0;
      else if (opcode_reg == OP_ENTER_QUAD && second_cfg_reg.quad_enable)
        quad_instruction_mode_reg <= 1'b1;
      else if (opcode_reg == OP_EXIT_QUAD)
        quad_instruction_mode_reg <= 1'b0;
    end
  end

  // software reset needs the enable instruction in the frame just before
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reset_armed_reg <= 1'b0;
    else if (exec)
      reset_armed_reg <= (opcode_reg == OP_RESET_ENABLE);
  end

  // registered outputs; per-block locks are all set after any reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_out <= {THIRD_RESET, SECOND_RESET, FIRST_RESET};
      quad_instruction_mode <= 1'b0;
      block_locks_set <= 1'b1;
    end
    else
    begin
      status_out <= {third_view, second_view, first_view};
      quad_instruction_mode <= quad_instruction_mode_reg;
      block_locks_set <= dev_reset;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wel_set;
    write_enable_latch_reg && !busy;
  endsequence
  sequence s_run_steady;
    busy [*8];
  endsequence

  property p_busy_start;
    start_op && !dev_reset |=> s_run_steady;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not held after start");

  property p_busy_end;
    busy && busy_cnt_reg == BUSY_CNT_W'(1) && !exec && !dev_reset |=> !busy ##1 !status_out.first.busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not cleared at completion");

  property p_ignore_busy;
    busy && ev.frame_end && opcode_reg == OP_WRITE_ENABLE && !dev_reset |=> $stable(write_enable_latch_reg);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("instruction obeyed while busy");

  property p_wel_set;
    exec && frame_ok_reg && opcode_reg == OP_WRITE_ENABLE && !dev_reset |=> s_wel_set;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("write enable latch not set");

  property p_wel_clear;
    cfg_write |=> !write_enable_latch_reg ##1 !status_out.first.write_enable_latch;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared after write");

  property p_hw_protect;
    protect_mode == PROT_HARDWARE && !wp_meta_reg[1] && !second_cfg_reg.quad_enable |-> !cfg_write;
  endproperty
  a_hw_protect: assert property (p_hw_protect) else $error("write taken with protect pin low");

  property p_lockdown;
    second_cfg_reg.reg_protect_hi |-> !cfg_write;
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("write taken under lock-down");

  property p_secure_sticky;
    second_cfg_reg.secure_lock_1 |=> second_cfg_reg.secure_lock_1 [*3];
  endproperty
  a_secure_sticky: assert property (p_secure_sticky) else $error("lock bit cleared");

  property p_quad_keep;
    quad_instruction_mode_reg |-> second_cfg_reg.quad_enable;
  endproperty
  a_quad_keep: assert property (p_quad_keep) else $error("quad enable lost in quad mode");

  property p_suspend;
    busy && exec && opcode_reg == OP_SUSPEND && !dev_reset |=> !busy ##1 status_out.second.suspend_flag;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend flag not set");

  property p_reset_mode;
    dev_reset |=> current_addr_mode_reg == $past(third_cfg_reg.powerup_addr_mode);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("address mode not loaded at reset");

endmodule : flash_status_config_regs
`default_nettype wire

// ===== test/spi_host_model.sv
/*
  serial host model: mode 0 frames, msb first, 225 ns sclk period.
  assumes clk at 40 MHz; pins change only after clk rising edges.
*/
`default_nettype none
module spi_host_model (
  // pins toward the device
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic di,
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  // idle pins: clock low, not selected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di = 1'b0;
  end
  // one byte, sclk high for four clk cycles and low for five
  task byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk);
      di <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rx[i] = dout_oe ? dout : ~last; // a released line shows the inverse
      last = rx[i];
      sclk <= 1'b0;
    end
  endtask : byte_x
  // n bytes from the top of tx, rx keeps the last byte read
  task frame(input int n, input logic [31:0] tx, output logic [7:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int k = 0; k < n; k++)
      byte_x(tx[31 - 8 * k -: 8], rx);
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    di <= ~di; // data line keeps moving between frames
    repeat (24) @(posedge clk);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ===== test/tb_flash_status_config_regs.sv
/*
  bench of the status register bank: instruction frames through the host model.
  assumes the package constants and a 40 MHz clk.
*/
`default_nettype none
module tb_flash_status_config_regs;
  import flash_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic sclk, cs_n, di, dout, dout_oe, qmode, locks;
  status_all_t st;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] rx;
  // 25 ns clock
  always #12.5 clk = ~clk;
  // device and host
  flash_status_config_regs i_flash_status_config_regs (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .io0_di(di), .wp_io2_n(wp_n), .hold_io3_n(1'b1), .io1_out(dout), .io1_oe(dout_oe), .status_out(st),
    .quad_instruction_mode(qmode), .block_locks_set(locks));
  spi_host_model i_spi_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .di(di), .dout(dout),
    .dout_oe(dout_oe));
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // bounded wait for busy to drop
  task idle;
    int n;
    n = 0;
    while (st.first.busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 3000)
    begin
      chk(1, 0);
      test_done;
    end
  endtask : idle
  task f(input int n, input logic [31:0] tx);
    i_spi_host_model.frame(n, tx, rx);
  endtask : f
  // enabled register write, then wait for completion
  task wr(input logic [7:0] op, input logic [7:0] d);
    f(1, {OP_WRITE_ENABLE, 24'h0});
    f(2, {op, d, 16'h0});
    idle;
  endtask : wr
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    chk(locks, 1);
    chk(st, 24'h600000);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    f(2, {OP_READ_THIRD, 24'h0});
    chk(rx, 8'h60);
    f(1, {OP_WRITE_ENABLE, 24'h0});
    chk(st.first, 8'h02);
    f(1, {OP_WRITE_DISABLE, 24'h0});
    chk(st.first, 8'h00);
    f(1, {OP_ENTER_QUAD, 24'h0});
    chk(qmode, 0);
    f(1, {OP_WRITE_ENABLE, 24'h0});
    f(2, {OP_WRITE_FIRST, 8'h7f, 16'h0});
    chk(st.first, 8'h7d);
    f(1, {OP_WRITE_ENABLE, 24'h0});
    f(2, {OP_READ_FIRST, 24'h0});
    chk(rx, 8'h7d);
    idle;
    chk(st.first, 8'h7c);
    wr(OP_WRITE_FIRST, 8'h80);
    wp_n <= 1'b0;
    wr(OP_WRITE_FIRST, 8'h00);
    chk(st.first[7], 1);
    wp_n <= 1'b1;
    wr(OP_WRITE_FIRST, 8'h00);
    chk(st.first, 8'h00);
    wp_n <= 1'b0;
    wr(OP_WRITE_SECOND, 8'h4a);
    chk(st.second, 8'h4a);
    wp_n <= 1'b1;
    f(1, {OP_ENTER_QUAD, 24'h0});
    chk(qmode, 1);
    wr(OP_WRITE_SECOND, 8'h00);
    chk(st.second, 8'h0a);
    wr(OP_WRITE_THIRD, 8'h62);
    chk(st.third, 8'h62);
    f(1, {OP_RESET_ENABLE, 24'h0});
    f(1, {OP_RESET, 24'h0});
    chk({qmode, st.third}, 9'h063);
    f(1, {OP_WRITE_ENABLE, 24'h0});
    f(4, {OP_SECTOR_ERASE, 24'h0});
    chk(st.first[0], 1);
    f(1, {OP_SUSPEND, 24'h0});
    chk(st.second[7], 1);
    f(1, {OP_RESUME, 24'h0});
    chk(st.second[7], 0);
    idle;
    wr(OP_WRITE_SECOND, 8'h0b);
    wr(OP_WRITE_SECOND, 8'h0a);
    chk(st.second, 8'h0b);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(st, 24'h600000);
    repeat (3) @(posedge clk);
    // both protect bits set: every later register write is refused
    f(1, {OP_WRITE_ENABLE, 24'h0});
    f(3, {OP_WRITE_FIRST, 8'h80, 8'h01, 8'h0});
    idle;
    wr(OP_WRITE_SECOND, 8'h00);
    chk({st.second, st.first}, 16'h0182);
    test_done;
  end
endmodule : tb_flash_status_config_regs
`default_nettype wire
